// File: rtl/omc_pkg.sv
// Package of constants and types for the operating mode control block.
`default_nettype none
package omc_pkg;
	// ==========================================================
	// Register offsets (byte addresses on the bus)
	// ==========================================================
	localparam logic [7:0] ADDR_MODE    = 8'h0B;
	localparam logic [7:0] ADDR_RAM_POS = 8'h10;
	localparam logic [7:0] ADDR_REG_POS = 8'h11;
	localparam logic [7:0] ADDR_EE_POS  = 8'h12;
	localparam logic [7:0] ADDR_STATUS  = 8'h20;
	localparam logic [7:0] ADDR_DEBUG   = 8'h24;
	localparam int         ADDR_W       = 8;

	// ==========================================================
	// Mode register field positions
	// ==========================================================
	localparam int BIT_SPECIAL_MODE_LOW_FLAG  = 7;
	localparam int BIT_MODE_SELECT_HIGH   = 6;
	localparam int BIT_MODE_SELECT_LOW   = 5;
	localparam int BIT_E_CLOCK_STRETCH_ENABLE   = 4;
	localparam int BIT_INTERNAL_VISIBILITY   = 3;
	localparam int BIT_BUS_STOP_IN_WAIT = 2;
	localparam int BIT_EMK    = 1;
	localparam int BIT_EME    = 0;

	// ==========================================================
	// Mapping register masks and reset values
	// ==========================================================
	localparam logic [7:0] RAM_POS_MASK  = 8'hE0;
	localparam logic [7:0] RAM_POS_RESET = 8'h20;
	localparam logic [7:0] REG_POS_MASK  = 8'hF9;
	localparam logic [7:0] REG_POS_RESET = 8'h00;
	localparam logic [7:0] EE_POS_MASK   = 8'hF1;
	localparam logic [7:0] EE_POS_RESET  = 8'h01;
	localparam logic [7:0] REG_WAI_BIT   = 8'h01;
	localparam logic [7:0] EE_ON_BIT     = 8'h01;

	// ==========================================================
	// Debug ROM and debug register windows
	// ==========================================================
	localparam logic [15:0] DBG_ROM_LO = 16'hFF20;
	localparam logic [15:0] DBG_REG_LO = 16'hFF00;
	localparam logic [15:0] DBG_REG_HI = 16'hFF06;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int CLK_HZ        = 25_000_000;
	localparam int STOP_DELAY_NS = 200;
	localparam int STOP_DELAY_CY = (STOP_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int MAP_DELAY_CY  = 2;

	// ==========================================================
	// Modes {special_n, high, low}
	// ==========================================================
	typedef enum logic [2:0] {
		OMC_SPEC_SINGLE = 3'h0,
		OMC_SPEC_NARROW = 3'h1,
		OMC_SPEC_PERIPH = 3'h2,
		OMC_SPEC_WIDE   = 3'h3,
		OMC_NORM_SINGLE = 3'h4,
		OMC_NORM_NARROW = 3'h5,
		OMC_NORM_RSVD   = 3'h6,
		OMC_NORM_WIDE   = 3'h7
	} omc_mode_e;

	// Narrow-bus transfer states; IDLE 0, HIGH 1, LOW 3 (LOW back to IDLE changes two bits).
	typedef enum logic [1:0] {
		OMC_NB_IDLE = 2'h0,
		OMC_NB_HIGH = 2'h1,
		OMC_NB_LOW  = 2'h3
	} omc_nb_e;

	// Address-decode result of the internal map.
	typedef struct packed {
		logic dbg_rom;
		logic dbg_reg;
		logic reg_blk;
		logic ram;
		logic eeprom;
		logic port_e;
		logic port_k;
		logic external;
	} omc_hit_s;

	// Bus-configuration outputs.
	typedef struct packed {
		logic e_clock_stretch_enable;
		logic internal_visibility;
		logic bus_stop_in_wait;
		logic emulate_port_k;
		logic emulate_port_e;
		logic expanded;
		logic narrow;
		logic special;
	} omc_cfg_s;
endpackage
`default_nettype wire

// File: rtl/omc_top.sv
// Operating mode control register bank with mapping, debug and bus control.
// How it works
// - Pins latched into mode bits at reset.
// - Special flag writable in special; first ignored.
// - Mode bits write rules; peripheral/reserved unselectable.
// - Stretch enable selects free or stretched E.
// - Stretch enable reads one in expanded modes.
// - Stretch enable write once normal, anytime special.
// - Visibility drives internal cycles outside; not single-chip.
// - Special narrow visible data shown wide.
// - Visibility and emulation bits: once/except first.
// - Bus stops in wait after drain delay.
// - Bus stop bit writable only normal modes.
// - Port K emulation unmaps port K registers outside single-chip.
// - Port E emulation unmaps port E registers in expanded modes.
// - Mode register absent in peripheral mode.
// - Peripheral mode: CPU idle, reset-only entry.
// - Debug active after reset in special single.
// - Debug activates by serial command or instruction.
// - Debug ROM and registers overlay top page.
// - Mapping writes take effect two cycles later.
// - Position registers write once in normal modes.
// - Register block beats RAM, EEPROM; ROM beats all.
// - Narrow mode splits words, high byte first.
// - Reserved reset mode forced to peripheral.
`default_nettype none
module omc_top #(
	parameter int STOP_CY = omc_pkg::STOP_DELAY_CY
) (
	// Clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	// Mode straps (pins)
	input  wire logic                     debug_serial_pin_i,
	input  wire logic                     mode_select_high_i,
	input  wire logic                     mode_select_low_i,
	// Wishbone slave
	input  wire logic                     cyc_i,
	input  wire logic                     stb_i,
	input  wire logic                     we_i,
	input  wire logic [omc_pkg::ADDR_W-1:0] adr_i,
	input  wire logic [3:0]               sel_i,
	input  wire logic [31:0]              dat_i,
	output logic [31:0]                   dat_o,
	output logic                          ack_o,
	// CPU-side events (same clock)
	input  wire logic                     wait_mode_i,
	input  wire logic                     ext_bus_busy_i,
	input  wire logic                     debug_cmd_i,
	input  wire logic                     debug_halt_instruction_i,
	input  wire logic                     debug_exit_i,
	input  wire logic                     int_access_i,
	input  wire logic                     word_access_i,
	input  wire logic                     bus_req_i,
	input  wire logic [15:0]              cpu_addr_i,
	// Outputs
	output omc_pkg::omc_cfg_s             cfg_o,
	output omc_pkg::omc_hit_s             hit_o,
	output logic                          background_debug_o,
	output logic                          cpu_halt_o,
	output logic                          bus_stopped_o,
	output logic                          e_stretch_o,
	output logic                          visible_o,
	output logic                          wide_visible_o,
	output logic [15:0]                   nb_addr_o,
	output logic                          nb_high_o,
	output logic                          nb_active_o
);
	// ==========================================================
	// Elaboration checks
	// ==========================================================
	if (STOP_CY < 1 || STOP_CY > 65535) begin : g_chk
		$error("STOP_CY must lie between 1 and 65535");
	end

	function automatic logic is_special(input logic [2:0] m);
		return ~m[2] | (m == omc_pkg::OMC_NORM_RSVD);
	endfunction
	function automatic logic is_expanded(input logic [2:0] m);
		return m[0];
	endfunction
	function automatic logic is_periph(input logic [2:0] m);
		return m[1] & ~m[0];
	endfunction
	function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	// ==========================================================
	// Strap synchronisers and reset-release capture
	// ==========================================================
	logic [2:0] pin_s1, pin_s2;
	logic       rst_d;
	always_ff @(posedge clk_i) begin
		pin_s1 <= {debug_serial_pin_i, mode_select_high_i, mode_select_low_i};
		pin_s2 <= pin_s1;
		rst_d  <= rst_i;
	end

	// ==========================================================
	// Register state
	// ==========================================================
	logic [2:0] mode, next_mode;
	logic [4:0] cfg, next_cfg;            // e_clock_stretch_enable, internal_visibility, bus_stop_in_wait, emk, eme
	logic [4:0] once, next_once;          // write-once used: modes, e_clock_stretch_enable, internal_visibility/emk/eme, pos regs...
	logic       first_seen, next_first_seen;
	logic       first_seen_ee, next_first_seen_ee;
	logic [7:0] ram_pos, next_ram_pos, reg_pos, next_reg_pos, ee_pos, next_ee_pos;
	logic [7:0] ram_eff, next_ram_eff, reg_eff, next_reg_eff, ee_eff, next_ee_eff;
	logic       map_pend, next_map_pend;
	logic       dbg_en, next_dbg_en, dbg_act, next_dbg_act;
	logic       ack, next_ack;
	logic [31:0] rdat, next_rdat;
	logic       capture;
	logic       wr;
	logic [7:0] wb;
	logic       spec;

	assign capture = rst_d & ~rst_i;
	assign spec    = is_special(mode);
	assign wr      = cyc_i & stb_i & we_i & ~ack & sel_i[0];
	assign wb      = dat_i[7:0];

	always_comb begin
		logic [2:0] m;
		logic       mode_hit;
		m               = mode;
		next_mode       = mode;
		next_cfg        = cfg;
		next_once       = once;
		next_first_seen = first_seen;
		next_ram_pos    = ram_pos;
		next_reg_pos    = reg_pos;
		next_ee_pos     = ee_pos;
		next_ram_eff    = ram_eff;
		next_reg_eff    = reg_eff;
		next_ee_eff     = ee_eff;
		next_map_pend   = 1'b0;
		next_dbg_en     = dbg_en;
		next_dbg_act    = dbg_act;
		next_ack        = cyc_i & stb_i & ~ack;
		next_rdat       = 32'h0000_0000;
		mode_hit        = ~is_periph(mode);
		if (capture) begin
			m = pin_s2;
			if (m == omc_pkg::OMC_NORM_RSVD)
				m = omc_pkg::OMC_SPEC_PERIPH;
			next_mode       = m;
			next_cfg        = is_special(m) ? 5'h1B : 5'h10;
			next_once       = 5'h00;
			next_first_seen = 1'b0;
			next_dbg_en     = (m == omc_pkg::OMC_SPEC_SINGLE);
			next_dbg_act    = (m == omc_pkg::OMC_SPEC_SINGLE);
		end else if (wr && adr_i == omc_pkg::ADDR_MODE && mode_hit) begin
			next_first_seen = 1'b1;
			if (spec) begin
				if (first_seen) begin
					if (~wb[omc_pkg::BIT_SPECIAL_MODE_LOW_FLAG]) m[2] = 1'b0;
					else m[2] = 1'b1;
					m[1:0] = wb[omc_pkg::BIT_MODE_SELECT_HIGH:omc_pkg::BIT_MODE_SELECT_LOW];
					if (is_periph(m) || m == omc_pkg::OMC_NORM_RSVD) m = mode;
					next_mode   = m;
					next_cfg[3] = wb[omc_pkg::BIT_INTERNAL_VISIBILITY];
					next_cfg[1] = wb[omc_pkg::BIT_EMK];
					next_cfg[0] = wb[omc_pkg::BIT_EME];
				end
				next_cfg[4] = wb[omc_pkg::BIT_E_CLOCK_STRETCH_ENABLE];
			end else begin
				if (!once[0]) begin
					m[1:0] = wb[omc_pkg::BIT_MODE_SELECT_HIGH:omc_pkg::BIT_MODE_SELECT_LOW];
					if (!is_periph(m)) next_mode = m;
					next_once[0] = 1'b1;
				end
				if (!once[1]) begin
					next_cfg[4]  = wb[omc_pkg::BIT_E_CLOCK_STRETCH_ENABLE];
					next_once[1] = 1'b1;
				end
				if (!once[2]) begin
					next_cfg[3]  = wb[omc_pkg::BIT_INTERNAL_VISIBILITY];
					next_cfg[1]  = wb[omc_pkg::BIT_EMK];
					next_cfg[0]  = wb[omc_pkg::BIT_EME];
					next_once[2] = 1'b1;
				end
				next_cfg[2] = wb[omc_pkg::BIT_BUS_STOP_IN_WAIT];
			end
		end else if (wr && adr_i == omc_pkg::ADDR_RAM_POS && (spec || !once[3])) begin
			next_ram_pos  = wb & omc_pkg::RAM_POS_MASK;
			next_once[3]  = ~spec | once[3];
			next_map_pend = 1'b1;
		end else if (wr && adr_i == omc_pkg::ADDR_REG_POS) begin
			if (spec || !once[4]) begin
				next_reg_pos[7:3] = wb[7:3];
				next_once[4]      = ~spec | once[4];
			end
			if (!spec) next_reg_pos[0] = wb[0];
			next_map_pend = 1'b1;
		end else if (wr && adr_i == omc_pkg::ADDR_EE_POS) begin
			if (spec || !first_seen_ee) next_ee_pos[7:4] = wb[7:4];
			next_ee_pos[0] = wb[0];
			next_map_pend  = 1'b1;
		end else if (wr && adr_i == omc_pkg::ADDR_DEBUG) begin
			next_dbg_en = wb[0];
		end
		// A pending mapping write becomes effective the cycle after it lands.
		if (map_pend) begin
			next_ram_eff = ram_pos;
			next_reg_eff = reg_pos;
			next_ee_eff  = ee_pos;
		end
		if (dbg_en && !is_periph(mode) && (debug_cmd_i || debug_halt_instruction_i))
			next_dbg_act = 1'b1;
		else if (debug_exit_i && !capture)
			next_dbg_act = 1'b0;
		// Read mux.
		case (adr_i)
			omc_pkg::ADDR_MODE:    next_rdat[7:0] = mode_hit ?
				{mode, cfg[4] | is_expanded(mode), cfg[3:0]} : 8'h00;
			omc_pkg::ADDR_RAM_POS: next_rdat[7:0] = ram_pos;
			omc_pkg::ADDR_REG_POS: next_rdat[7:0] = reg_pos;
			omc_pkg::ADDR_EE_POS:  next_rdat[7:0] = ee_pos;
			omc_pkg::ADDR_STATUS:  next_rdat[7:0] = {4'h0, bus_stopped_o, dbg_act, dbg_en, map_pend};
			omc_pkg::ADDR_DEBUG:   next_rdat[7:0] = {7'h00, dbg_en};
			default:               next_rdat = 32'h0000_0000;
		endcase
	end

	// EEPROM position is write-once in normal modes; tracked separately.
	always_comb begin
		next_first_seen_ee = first_seen_ee;
		if (capture)
			next_first_seen_ee = 1'b0;
		else if (wr && adr_i == omc_pkg::ADDR_EE_POS && !spec)
			next_first_seen_ee = 1'b1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode          <= omc_pkg::OMC_SPEC_SINGLE;
			cfg           <= 5'h1B;
			once          <= 5'h00;
			first_seen    <= 1'b0;
			first_seen_ee <= 1'b0;
			ram_pos       <= omc_pkg::RAM_POS_RESET;
			reg_pos       <= omc_pkg::REG_POS_RESET;
			ee_pos        <= omc_pkg::EE_POS_RESET;
			ram_eff       <= omc_pkg::RAM_POS_RESET;
			reg_eff       <= omc_pkg::REG_POS_RESET;
			ee_eff        <= omc_pkg::EE_POS_RESET;
			map_pend      <= 1'b0;
			dbg_en        <= 1'b0;
			dbg_act       <= 1'b0;
			ack           <= 1'b0;
			rdat          <= 32'h0000_0000;
		end else begin
			mode          <= next_mode;
			cfg           <= next_cfg;
			once          <= next_once;
			first_seen    <= next_first_seen;
			first_seen_ee <= next_first_seen_ee;
			ram_pos       <= next_ram_pos;
			reg_pos       <= next_reg_pos;
			ee_pos        <= next_ee_pos;
			ram_eff       <= next_ram_eff;
			reg_eff       <= next_reg_eff;
			ee_eff        <= next_ee_eff;
			map_pend      <= next_map_pend;
			dbg_en        <= next_dbg_en;
			dbg_act       <= next_dbg_act;
			ack           <= next_ack;
			rdat          <= next_rdat;
		end
	end
	assign ack_o = ack;
	assign dat_o = rdat;

	// ==========================================================
	// Bus stop in wait, with drain delay
	// ==========================================================
	logic [15:0] stop_cnt, next_stop_cnt;
	logic        stopped, next_stopped;
	always_comb begin
		next_stop_cnt = stop_cnt;
		next_stopped  = 1'b0;
		if (!(cfg[2] && wait_mode_i) || ext_bus_busy_i)
			next_stop_cnt = 16'h0000;
		else if (stop_cnt < 16'(STOP_CY))
			next_stop_cnt = stop_cnt + 16'h0001;
		if (cfg[2] && wait_mode_i && stop_cnt >= 16'(STOP_CY))
			next_stopped = 1'b1;
	end

	// ==========================================================
	// Address decode, visibility and narrow-bus splitting
	// ==========================================================
	omc_pkg::omc_hit_s next_hit;
	omc_pkg::omc_nb_e  nb, next_nb;
	logic [15:0]       nb_addr, next_nb_addr;
	logic              next_estretch, next_vis, next_wide;
	logic              single;
	assign single = ~is_expanded(mode) & ~is_periph(mode);
	always_comb begin
		next_hit          = '0;
		next_hit.dbg_rom  = dbg_act && cpu_addr_i >= omc_pkg::DBG_ROM_LO;
		next_hit.dbg_reg  = dbg_act && in_range(cpu_addr_i, omc_pkg::DBG_REG_LO, omc_pkg::DBG_REG_HI);
		if (!next_hit.dbg_rom && !next_hit.dbg_reg && !(dbg_act && cpu_addr_i >= omc_pkg::DBG_REG_LO)) begin
			next_hit.reg_blk = cpu_addr_i[15:11] == reg_eff[7:3] && !cpu_addr_i[10];
			next_hit.ram     = !next_hit.reg_blk && cpu_addr_i[15:13] == ram_eff[7:5];
			next_hit.eeprom  = !next_hit.reg_blk && !next_hit.ram && ee_eff[0] &&
				cpu_addr_i[15:12] == ee_eff[7:4] && cpu_addr_i[11];
			// Port registers drop out when emulated externally.
			next_hit.port_e  = next_hit.reg_blk && !(cfg[0] && is_expanded(mode));
			next_hit.port_k  = next_hit.reg_blk && !(cfg[1] && !single);
			next_hit.external = !single && !next_hit.reg_blk && !next_hit.ram && !next_hit.eeprom;
		end
		next_vis      = cfg[3] && !single && int_access_i && bus_req_i;
		next_wide     = next_vis && mode == omc_pkg::OMC_SPEC_NARROW;
		next_estretch = (cfg[4] | is_expanded(mode)) &&
			(next_hit.external ? 1'b1 : (int_access_i && !cfg[3]));
		next_nb      = nb;
		next_nb_addr = nb_addr;
		case (nb)
			omc_pkg::OMC_NB_IDLE: begin
				if (bus_req_i && word_access_i && next_hit.external && mode[1:0] == 2'h1) begin
					next_nb      = omc_pkg::OMC_NB_HIGH;
					next_nb_addr = cpu_addr_i;
				end
			end
			omc_pkg::OMC_NB_HIGH: begin
				next_nb      = omc_pkg::OMC_NB_LOW;
				next_nb_addr = nb_addr + 16'h0001;
			end
			omc_pkg::OMC_NB_LOW: next_nb = omc_pkg::OMC_NB_IDLE;
			default:             next_nb = omc_pkg::OMC_NB_IDLE;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stop_cnt <= 16'h0000;
			stopped  <= 1'b0;
			hit_o    <= '0;
			nb       <= omc_pkg::OMC_NB_IDLE;
			nb_addr  <= 16'h0000;
			nb_high_o   <= 1'b0;
			nb_active_o <= 1'b0;
			e_stretch_o    <= 1'b0;
			visible_o      <= 1'b0;
			wide_visible_o <= 1'b0;
		end else begin
			stop_cnt <= next_stop_cnt;
			stopped  <= next_stopped;
			hit_o    <= next_hit;
			nb       <= next_nb;
			nb_addr  <= next_nb_addr;
			nb_high_o   <= next_nb == omc_pkg::OMC_NB_HIGH;
			nb_active_o <= next_nb != omc_pkg::OMC_NB_IDLE;
			e_stretch_o    <= next_estretch;
			visible_o      <= next_vis;
			wide_visible_o <= next_wide;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_o              <= '0;
			background_debug_o <= 1'b0;
			cpu_halt_o         <= 1'b0;
		end else begin
			cfg_o              <= '{e_clock_stretch_enable: cfg[4] | is_expanded(mode), internal_visibility: cfg[3], bus_stop_in_wait: cfg[2],
				emulate_port_k: cfg[1], emulate_port_e: cfg[0], expanded: is_expanded(mode) | is_periph(mode),
				narrow: mode[1:0] == 2'h1, special: spec};
			background_debug_o <= next_dbg_act;
			cpu_halt_o         <= is_periph(next_mode);
		end
	end
	assign bus_stopped_o = stopped;
	assign nb_addr_o     = nb_addr;
endmodule
`default_nettype wire

// File: testbench/omc_ext_model.sv
// Behavioural model of the external bus memory beside the block.
`default_nettype none
module omc_ext_model #(
	parameter int BUSY_CY = 3
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Bus activity
	input  wire logic req_i,
	output logic      busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	int next_cnt;
	// ======================================================
	// Busy time
	// ======================================================
	// Each request leaves a few cycles of final bus activity to drain.
	always_comb begin
		next_cnt = (cnt > 0) ? cnt - 1 : 0;
		if (req_i) next_cnt = BUSY_CY;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) cnt <= 0;
		else cnt <= next_cnt;
	end
	assign busy_o = (cnt != 0);
endmodule
`default_nettype wire

// File: testbench/omc_top_assertions.sv
// Port checker for the operating mode control block.
`default_nettype none
module omc_checker #(
	parameter int STOP_CY = 5
) (
	// Clock, reset and straps
	input wire logic              clk_i,
	input wire logic              rst_i,
	input wire logic              debug_serial_pin_i,
	input wire logic              mode_select_high_i,
	input wire logic              mode_select_low_i,
	// Bus and CPU side
	input wire logic              cyc_i,
	input wire logic              stb_i,
	input wire logic              ack_o,
	input wire logic              wait_mode_i,
	input wire logic              ext_bus_busy_i,
	input wire logic [15:0]       cpu_addr_i,
	// Outputs
	input wire omc_pkg::omc_cfg_s cfg_o,
	input wire omc_pkg::omc_hit_s hit_o,
	input wire logic              background_debug_o,
	input wire logic              bus_stopped_o,
	input wire logic              visible_o,
	input wire logic              wide_visible_o,
	input wire logic [15:0]       nb_addr_o,
	input wire logic              nb_high_o,
	input wire logic              nb_active_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ======================================================
	// Properties
	// ======================================================
	property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
	property p_e_clock_stretch_enable; cfg_o.expanded |-> cfg_o.e_clock_stretch_enable; endproperty
	property p_vis; visible_o |-> cfg_o.expanded; endproperty
	property p_wide; wide_visible_o |-> cfg_o.narrow && cfg_o.special && cfg_o.internal_visibility; endproperty
	property p_bdm_boot;
		$fell(rst_i) && !debug_serial_pin_i && !mode_select_high_i && !mode_select_low_i |-> ##[1:6] background_debug_o;
	endproperty
	property p_rom;
		hit_o.dbg_rom |-> $past(background_debug_o) && $past(cpu_addr_i) >= omc_pkg::DBG_ROM_LO;
	endproperty
	property p_prec;
		$onehot0({hit_o.dbg_rom, hit_o.dbg_reg, hit_o.reg_blk, hit_o.ram, hit_o.eeprom, hit_o.external}) &&
			(!(hit_o.port_e || hit_o.port_k) || hit_o.reg_blk);
	endproperty
	property p_nb_first; $rose(nb_active_o) |-> nb_high_o; endproperty
	property p_nb_inc;
		nb_active_o && nb_high_o ##1 nb_active_o && !nb_high_o |-> nb_addr_o == $past(nb_addr_o) + 16'h0001;
	endproperty
	property p_drain; $rose(wait_mode_i) |=> !bus_stopped_o [*4]; endproperty
	property p_stop; (wait_mode_i && cfg_o.bus_stop_in_wait && !ext_bus_busy_i) [*8] |=> bus_stopped_o; endproperty
	property p_run; (!wait_mode_i || !cfg_o.bus_stop_in_wait) [*2] |-> !bus_stopped_o; endproperty
	// ======================================================
	// Assertions
	// ======================================================
	a_ack: assert property (p_ack) else $error("bus answer not a one cycle pulse");
	a_e_clock_stretch_enable: assert property (p_e_clock_stretch_enable) else $error("stretch enable low in expanded mode");
	a_vis: assert property (p_vis) else $error("visibility in single chip mode");
	a_wide: assert property (p_wide) else $error("wide visibility outside narrow special");
	a_bdm_boot: assert property (p_bdm_boot) else $error("debug not active after boot");
	a_rom: assert property (p_rom) else $error("debug rom hit without debug");
	a_prec: assert property (p_prec) else $error("more than one resource hit");
	a_nb_first: assert property (p_nb_first) else $error("narrow transfer not high first");
	a_nb_inc: assert property (p_nb_inc) else $error("narrow second address wrong");
	a_drain: assert property (p_drain) else $error("bus stopped without drain delay");
	a_stop: assert property (p_stop) else $error("bus not stopped in wait");
	a_run: assert property (p_run) else $error("bus stopped outside wait");
	c_nb: cover property ($rose(nb_active_o));
	c_stop: cover property ($rose(bus_stopped_o));
	c_bdm: cover property ($rose(background_debug_o));
endmodule
bind omc_top omc_checker #(.STOP_CY(STOP_CY)) u_omc_checker (.clk_i, .rst_i, .debug_serial_pin_i,
	.mode_select_high_i, .mode_select_low_i, .cyc_i, .stb_i, .ack_o, .wait_mode_i, .ext_bus_busy_i, .cpu_addr_i,
	.cfg_o, .hit_o, .background_debug_o, .bus_stopped_o, .visible_o, .wide_visible_o, .nb_addr_o, .nb_high_o,
	.nb_active_o);
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the operating mode control block.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] AM = omc_pkg::ADDR_MODE;
	localparam logic [7:0] MODE_RST [8] = '{8'h1B, 8'h3B, 8'h00, 8'h7B, 8'h90, 8'hB0, 8'h00, 8'hF0};
	logic              clk_i = 0, rst_i = 1, debug_serial_pin_i = 0, mode_select_high_i = 0, mode_select_low_i = 0;
	logic              cyc_i = 0, stb_i = 0, we_i = 0, wait_mode_i = 0, int_access_i = 0, word_access_i = 0;
	logic              bus_req_i = 0, ack_o, ext_bus_busy_i, background_debug_o, cpu_halt_o, bus_stopped_o;
	logic              e_stretch_o, visible_o, wide_visible_o, nb_high_o, nb_active_o;
	logic [2:0]        dbg_ev = 0;
	logic [7:0]        adr_i = 0, q;
	logic [31:0]       dat_i = 0, dat_o;
	logic [15:0]       cpu_addr_i = 0, nb_addr_o;
	omc_pkg::omc_cfg_s cfg_o;
	omc_pkg::omc_hit_s hit_o;
	int                err_total = 0, n_compared = 0;
	always #20 clk_i = ~clk_i;
	omc_top u_omc_top (.clk_i, .rst_i, .debug_serial_pin_i, .mode_select_high_i, .mode_select_low_i, .cyc_i, .stb_i,
		.we_i, .adr_i, .sel_i(4'h1), .dat_i, .dat_o, .ack_o, .wait_mode_i, .ext_bus_busy_i, .debug_cmd_i(dbg_ev[0]),
		.debug_halt_instruction_i(dbg_ev[1]), .debug_exit_i(dbg_ev[2]), .int_access_i, .word_access_i, .bus_req_i,
		.cpu_addr_i, .cfg_o, .hit_o, .background_debug_o, .cpu_halt_o, .bus_stopped_o, .e_stretch_o, .visible_o,
		.wide_visible_o, .nb_addr_o, .nb_high_o, .nb_active_o);
	omc_ext_model u_omc_ext_model (.clk_i, .rst_i, .req_i(bus_req_i), .busy_o(ext_bus_busy_i));
	// ======================================================
	// Tasks
	// ======================================================
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		q = dat_o[7:0];
		chk(ack_o, 1);
		cyc_i <= 0;
		stb_i <= 0;
		we_i <= 0;
		@(posedge clk_i);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		wb(0, a, 8'h00);
		chk(q, e);
	endtask
	task automatic boot(input logic [2:0] s);
		rst_i <= 1;
		{debug_serial_pin_i, mode_select_high_i, mode_select_low_i} <= s;
		repeat (12) @(posedge clk_i);
		rst_i <= 0;
		repeat (4) @(posedge clk_i);
	endtask
	task automatic pulse(input int b);
		dbg_ev[b] <= 1;
		@(posedge clk_i);
		dbg_ev <= 0;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clk_i);
		err_total++;
		wrap_up();
	end
	// ======================================================
	// Sequence
	// ======================================================
	initial begin
		for (int i = 0; i < 8; i++) begin
			boot(i[2:0]);
			chk(background_debug_o, i == 0);
			rd_chk(AM, MODE_RST[i]);
			if (MODE_RST[i] == 8'h00) begin
				chk(cpu_halt_o, 1);
				wb(1, AM, 8'hFF);
				rd_chk(AM, 8'h00);
			end
		end
		boot(3'h0);
		wb(1, AM, 8'h20);
		rd_chk(AM, 8'h0B);
		wb(1, AM, 8'h57);
		rd_chk(AM, 8'h13);
		cpu_addr_i <= 16'h0010;
		wb(1, omc_pkg::ADDR_RAM_POS, 8'h00);
		repeat (3) @(posedge clk_i);
		chk({hit_o.reg_blk, hit_o.ram}, 2'b10);
		chk({hit_o.port_e, hit_o.port_k}, 2'b11);
		cpu_addr_i <= 16'h1000;
		repeat (3) @(posedge clk_i);
		chk(hit_o.ram, 1);
		boot(3'h7);
		wb(1, AM, 8'hF4);
		rd_chk(AM, 8'hF4);
		wb(1, AM, 8'h80);
		rd_chk(AM, 8'hF0);
		wb(1, omc_pkg::ADDR_RAM_POS, 8'hE0);
		wb(1, omc_pkg::ADDR_RAM_POS, 8'h40);
		rd_chk(omc_pkg::ADDR_RAM_POS, 8'hE0);
		rd_chk(8'hFF, 8'h00);
		wb(1, AM, 8'hF4);
		wait_mode_i <= 1;
		bus_req_i <= 1;
		@(posedge clk_i);
		bus_req_i <= 0;
		repeat (15) @(posedge clk_i);
		chk(bus_stopped_o, 1);
		wait_mode_i <= 0;
		repeat (3) @(posedge clk_i);
		chk(bus_stopped_o, 0);
		pulse(0);
		chk(background_debug_o, 0);
		wb(1, omc_pkg::ADDR_DEBUG, 8'h01);
		cpu_addr_i <= 16'hFF30;
		pulse(1);
		chk({background_debug_o, hit_o.dbg_rom}, 2'b11);
		pulse(2);
		chk(background_debug_o, 0);
		pulse(0);
		chk(background_debug_o, 1);
		boot(3'h1);
		cpu_addr_i <= 16'h4000;
		word_access_i <= 1;
		int_access_i <= 1;
		bus_req_i <= 1;
		repeat (6) @(posedge clk_i);
		chk({visible_o, wide_visible_o, e_stretch_o}, 3'b111);
		int_access_i <= 0;
		repeat (6) @(posedge clk_i);
		chk({visible_o, wide_visible_o}, 2'b00);
		bus_req_i <= 0;
		cpu_addr_i <= 16'h0010;
		repeat (4) @(posedge clk_i);
		chk({cfg_o.internal_visibility, cfg_o.narrow}, 2'b11);
		chk({hit_o.reg_blk, hit_o.port_e, hit_o.port_k}, 3'b100);
		wrap_up();
	end
endmodule
`default_nettype wire
